// >>> verilog/drcc_pkg.sv
// Package for the reference divider and comparator control block.
// Assumes a 32-bit AXI4-Lite register bus with one word per register.
package drcc_pkg;
  localparam logic [7:0] DRCC_OFS_REFCTL0 = 8'h00;
  localparam logic [7:0] DRCC_OFS_REFLVL = 8'h04;
  localparam logic [7:0] DRCC_OFS_CMPCTL0_0 = 8'h08;
  localparam logic [7:0] DRCC_OFS_CMPCTL1_0 = 8'h0c;
  localparam logic [7:0] DRCC_OFS_CMPCTL0_1 = 8'h10;
  localparam logic [7:0] DRCC_OFS_CMPCTL1_1 = 8'h14;
  localparam logic [7:0] DRCC_OFS_MIRROR = 8'h18;
  localparam logic [7:0] DRCC_OFS_IRQFLAG = 8'h1c;
  localparam int DRCC_REF_EN_BIT = 7;
  localparam int DRCC_REF_LPS_BIT = 6;
  localparam int DRCC_REF_OE_BIT = 5;
  localparam int DRCC_REF_PSS_LSB = 2;
  localparam int DRCC_REF_NSS_BIT = 0;
  localparam logic [7:0] DRCC_REFCTL0_MASK = 8'hed;
  localparam logic [7:0] DRCC_REFLVL_MASK = 8'h1f;
  localparam logic [7:0] DRCC_CMPCTL0_MASK = 8'hb7;
  localparam logic [7:0] DRCC_CMPCTL1_MASK = 8'hf3;
  localparam logic [7:0] DRCC_CMPCTL0_RST = 8'h04;
  localparam int DRCC_CMP_EN_BIT = 7;
  localparam int DRCC_CMP_RES_BIT = 6;
  localparam int DRCC_CMP_OE_BIT = 5;
  localparam int DRCC_CMP_POL_BIT = 4;
  localparam int DRCC_CMP_SP_BIT = 2;
  localparam int DRCC_CMP_HYS_BIT = 1;
  localparam int DRCC_CMP_SYNC_BIT = 0;
  localparam int DRCC_CMP_RISE_BIT = 7;
  localparam int DRCC_CMP_FALL_BIT = 6;
  localparam int DRCC_CMP_PCH_LSB = 4;
  localparam int DRCC_CMP_NCH_LSB = 0;
  localparam logic [1:0] DRCC_RESP_OKAY = 2'b00;
  localparam logic [1:0] DRCC_RESP_SLVERR = 2'b10;
endpackage

// >>> verilog/drcc_cmp_chan.sv
// One comparator channel: synchroniser, polarity, result latch, edge flags, pin path.
// Assumes raw analog result asynchronous and t1_clk_fall a one-cycle pulse.
`timescale 1ns/1ps
module drcc_cmp_chan
  import drcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic raw_result,
  input wire logic [7:0] ctl0,
  input wire logic [7:0] ctl1,
  input wire logic t1_clk_fall,
  input wire logic pin_direction,
  input wire logic flag_clear,
  output logic result_q,
  output logic gate_q,
  output logic flag_q,
  output logic pin_drive_q,
  output logic pin_oe_q
);
  logic sync1_q;
  logic sync2_q;
  logic pol_q;
  logic gate_d;
  wire logic enable = ctl0[DRCC_CMP_EN_BIT];
  wire logic polar = enable ? (sync2_q ^ ctl0[DRCC_CMP_POL_BIT]) : 1'b0;
  wire logic rise = polar & ~result_q & ctl1[DRCC_CMP_RISE_BIT];
  wire logic fall = ~polar & result_q & ctl1[DRCC_CMP_FALL_BIT];

  // Sync-on selects a Timer1 falling-edge latched copy for pin and gate
  assign gate_d = ctl0[DRCC_CMP_SYNC_BIT] ? (t1_clk_fall ? polar : gate_q) : polar;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      result_q <= 1'b0;
      gate_q <= 1'b0;
      flag_q <= 1'b0;
      pin_drive_q <= 1'b0;
      pin_oe_q <= 1'b0;
      pol_q <= 1'b0;
    end
    else
    begin
      sync1_q <= raw_result;
      sync2_q <= sync1_q;
      result_q <= polar;
      gate_q <= gate_d;
      flag_q <= rise | fall | (flag_q & ~flag_clear);
      pin_drive_q <= gate_d;
      pin_oe_q <= ctl0[DRCC_CMP_OE_BIT] & ~pin_direction & enable;
      pol_q <= ctl0[DRCC_CMP_POL_BIT];
    end
  end

  AST_FLAG_RISE: assert property (@(posedge aclk) disable iff (!aresetn)
    (polar && !result_q && ctl1[DRCC_CMP_RISE_BIT]) |=> flag_q)
    else $error("rising edge did not set flag");
  AST_FLAG_FALL: assert property (@(posedge aclk) disable iff (!aresetn)
    (!polar && result_q && ctl1[DRCC_CMP_FALL_BIT]) |=> flag_q)
    else $error("falling edge did not set flag");
  AST_PIN_OE: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_oe_q |-> $past(enable) && $past(ctl0[DRCC_CMP_OE_BIT]) && !$past(pin_direction))
    else $error("pin driven without all conditions");
  AST_SYNC_CHAIN: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && !ctl0[DRCC_CMP_POL_BIT] && $past(enable) && pol_q == 1'b0) |=> result_q == $past(sync2_q))
    else $error("result not from second sync stage");
endmodule // drcc_cmp_chan

// >>> verilog/drcc_top.sv
// Reference divider and dual comparator control with AXI4-Lite registers.
// Assumes analog blocks take the control outputs; Timer1 provides a falling-edge pulse.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module drcc_top
  import drcc_pkg::*;
#(
  parameter int NUM_CMP = 2
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_CMP-1:0] cmp_raw,
  input wire logic t1_clk_fall,
  input wire logic [NUM_CMP-1:0] pin_direction,
  output logic ref_enable_q,
  output logic ref_pos_connect_q,
  output logic ref_neg_connect_q,
  output logic [1:0] ref_pos_source_sel_q,
  output logic ref_neg_source_sel_q,
  output logic [4:0] ref_level_q,
  output logic ref_out_pin_q,
  output logic [NUM_CMP-1:0] cmp_enable_q,
  output logic [NUM_CMP-1:0] cmp_speed_power_q,
  output logic [NUM_CMP-1:0] cmp_hysteresis_enable_q,
  output logic [2*NUM_CMP-1:0] cmp_pos_input_sel_q,
  output logic [2*NUM_CMP-1:0] cmp_neg_input_sel_q,
  output logic [NUM_CMP-1:0] cmp_gate_q,
  output logic [NUM_CMP-1:0] cmp_pin_out_q,
  output logic [NUM_CMP-1:0] cmp_pin_oe_q,
  output logic [NUM_CMP-1:0] cmp_irq_flag_q
);
  logic [7:0] refctl0_q;
  logic [7:0] reflvl_q;
  logic [7:0] cctl0_q [NUM_CMP];
  logic [7:0] cctl1_q [NUM_CMP];
  logic [NUM_CMP-1:0] result;
  logic [NUM_CMP-1:0] flag_clr;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic [31:0] rdata_d;
  logic rd_hit;

  // Address and data may arrive in either order; both held until the write completes
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic [7:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
  wire logic [7:0] wr_byte = w_take ? (s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00) : wdata_q;
  // Lane 0 strobe kept with held data, so a strobe-less write that beats its address still writes nothing
  wire logic wr_lane0 = w_take ? s_axi_wstrb[0] : wlane_q;
  wire logic wr_go = (aw_held_q | aw_take) & (w_held_q | w_take) & ~s_axi_bvalid;
  wire logic wr_ok = wr_addr <= DRCC_OFS_IRQFLAG && wr_addr[1:0] == 2'b00;
  wire logic wr_en = wr_go & wr_ok & wr_lane0;
  wire logic rd_go = s_axi_arvalid & s_axi_arready;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      DRCC_OFS_REFCTL0: rdata_d[7:0] = refctl0_q;
      DRCC_OFS_REFLVL: rdata_d[7:0] = reflvl_q;
      DRCC_OFS_CMPCTL0_0: rdata_d[7:0] = cctl0_q[0] | {1'b0, result[0], 6'h00};
      DRCC_OFS_CMPCTL1_0: rdata_d[7:0] = cctl1_q[0];
      DRCC_OFS_CMPCTL0_1: rdata_d[7:0] = cctl0_q[1] | {1'b0, result[1], 6'h00};
      DRCC_OFS_CMPCTL1_1: rdata_d[7:0] = cctl1_q[1];
      DRCC_OFS_MIRROR: rdata_d[NUM_CMP-1:0] = result;
      DRCC_OFS_IRQFLAG: rdata_d[NUM_CMP-1:0] = cmp_irq_flag_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // Write one to clear; a same-cycle edge still wins inside the channel
  assign flag_clr = (wr_en && wr_addr == DRCC_OFS_IRQFLAG) ? wr_byte[NUM_CMP-1:0] : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DRCC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= DRCC_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        s_axi_awready <= 1'b0;
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take)
      begin
        s_axi_wready <= 1'b0;
        w_held_q <= 1'b1;
        wdata_q <= wr_byte;
        wlane_q <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? DRCC_RESP_OKAY : DRCC_RESP_SLVERR;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (rd_go)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rd_hit ? DRCC_RESP_OKAY : DRCC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Sleep is not seen here: register contents simply persist across it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      refctl0_q <= 8'h00;
      reflvl_q <= 8'h00;
    end
    else if (wr_en)
    begin
      if (wr_addr == DRCC_OFS_REFCTL0)
        refctl0_q <= wr_byte & DRCC_REFCTL0_MASK;
      if (wr_addr == DRCC_OFS_REFLVL)
        reflvl_q <= wr_byte & DRCC_REFLVL_MASK;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++)
    begin : g_cmp
      wire logic [7:0] ofs0 = DRCC_OFS_CMPCTL0_0 + 8'(8 * gi);
      wire logic [7:0] ofs1 = DRCC_OFS_CMPCTL1_0 + 8'(8 * gi);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cctl0_q[gi] <= DRCC_CMPCTL0_RST;
          cctl1_q[gi] <= 8'h00;
        end
        else if (wr_en)
        begin
          if (wr_addr == ofs0)
            cctl0_q[gi] <= wr_byte & DRCC_CMPCTL0_MASK;
          if (wr_addr == ofs1)
            cctl1_q[gi] <= wr_byte & DRCC_CMPCTL1_MASK;
        end
      end
      drcc_cmp_chan u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw_result(cmp_raw[gi]),
        .ctl0(cctl0_q[gi]),
        .ctl1(cctl1_q[gi]),
        .t1_clk_fall(t1_clk_fall),
        .pin_direction(pin_direction[gi]),
        .flag_clear(flag_clr[gi]),
        .result_q(result[gi]),
        .gate_q(cmp_gate_q[gi]),
        .flag_q(cmp_irq_flag_q[gi]),
        .pin_drive_q(cmp_pin_out_q[gi]),
        .pin_oe_q(cmp_pin_oe_q[gi])
      );
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cmp_enable_q[gi] <= 1'b0;
          cmp_speed_power_q[gi] <= 1'b1;
          cmp_hysteresis_enable_q[gi] <= 1'b0;
          cmp_pos_input_sel_q[2*gi +: 2] <= 2'b00;
          cmp_neg_input_sel_q[2*gi +: 2] <= 2'b00;
        end
        else
        begin
          cmp_enable_q[gi] <= cctl0_q[gi][DRCC_CMP_EN_BIT];
          cmp_speed_power_q[gi] <= cctl0_q[gi][DRCC_CMP_SP_BIT];
          cmp_hysteresis_enable_q[gi] <= cctl0_q[gi][DRCC_CMP_HYS_BIT];
          cmp_pos_input_sel_q[2*gi +: 2] <= cctl1_q[gi][DRCC_CMP_PCH_LSB +: 2];
          cmp_neg_input_sel_q[2*gi +: 2] <= cctl1_q[gi][DRCC_CMP_NCH_LSB +: 2];
        end
      end
    end
  endgenerate

  // Analog ladder controls; reserved source code 11 passed through untouched
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_enable_q <= 1'b0;
      ref_pos_connect_q <= 1'b0;
      ref_neg_connect_q <= 1'b0;
      ref_pos_source_sel_q <= 2'b00;
      ref_neg_source_sel_q <= 1'b0;
      ref_level_q <= 5'h00;
      ref_out_pin_q <= 1'b0;
    end
    else
    begin
      ref_enable_q <= refctl0_q[DRCC_REF_EN_BIT];
      ref_pos_connect_q <= refctl0_q[DRCC_REF_EN_BIT] | refctl0_q[DRCC_REF_LPS_BIT];
      ref_neg_connect_q <= refctl0_q[DRCC_REF_EN_BIT] | ~refctl0_q[DRCC_REF_LPS_BIT];
      ref_pos_source_sel_q <= refctl0_q[DRCC_REF_PSS_LSB +: 2];
      ref_neg_source_sel_q <= refctl0_q[DRCC_REF_NSS_BIT];
      ref_level_q <= reflvl_q[4:0];
      ref_out_pin_q <= refctl0_q[DRCC_REF_OE_BIT];
    end
  end

  AST_RESET_CLEARS: assert property (@(posedge aclk)
    !aresetn |=> !ref_enable_q && !ref_out_pin_q && ref_level_q == 5'h00)
    else $error("reset left reference active");
  AST_LPS_NEG: assert property (@(posedge aclk) disable iff (!aresetn)
    (!refctl0_q[DRCC_REF_EN_BIT] && refctl0_q[DRCC_REF_LPS_BIT]) |=> !ref_neg_connect_q)
    else $error("negative source not disconnected");
  AST_PIN_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ref_out_pin_q == $past(refctl0_q[DRCC_REF_OE_BIT]))
    else $error("pin enable not following register");
  AST_WR_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("write without response");
  AST_LVL_UPPER: assert property (@(posedge aclk) disable iff (!aresetn)
    reflvl_q[7:5] == 3'b000)
    else $error("level upper bits not zero");
endmodule // drcc_top

// >>> tb/drcc_t1_model.sv
// Timer1 prescaled clock and gate counter facing the comparator block.
// Assumes the bench raises run only while it wants Timer1 clock edges.
`timescale 1ns/1ps
module drcc_t1_model #(
  parameter int DIV = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic gate,
  output logic t1_clk_fall,
  output logic [7:0] t1_count_q
);
  int ph_q;
  // Clock stands still outside run, so no stray latch edges reach the block
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ph_q <= 0;
      t1_clk_fall <= 1'b0;
      t1_count_q <= 8'h00;
    end
    else
    begin
      ph_q <= run ? (ph_q + 1) % DIV : ph_q;
      t1_clk_fall <= run && ph_q == DIV - 1;
      // Counts half a period away from the falling edge, so no race
      if (run && ph_q == DIV / 2 - 1 && gate)
        t1_count_q <= t1_count_q + 8'h01;
    end
  end
endmodule // drcc_t1_model

// >>> tb/tb_top.sv
// Self-checking bench for the reference and comparator control block.
// Assumes an AXI4-Lite slave that answers on its own; the Timer1 model makes t1_clk_fall.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin $display("mismatch %s exp %h got %h", nm, e, g); num_errors++; end end
module tb_top
  import drcc_pkg::*;
();
  logic aclk = 1'b0, aresetn = 1'b0, t1_clk_fall, t1_run = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, cmp_raw = 2'b00, pin_direction = 2'b11, ref_pos_source_sel_q;
  logic ref_enable_q, ref_pos_connect_q, ref_neg_connect_q, ref_neg_source_sel_q, ref_out_pin_q;
  logic [4:0] ref_level_q;
  logic [1:0] cmp_enable_q, cmp_speed_power_q, cmp_hysteresis_enable_q, cmp_gate_q, cmp_pin_out_q, cmp_pin_oe_q;
  logic [1:0] cmp_irq_flag_q;
  logic [3:0] cmp_pos_input_sel_q, cmp_neg_input_sel_q;
  logic [34:0] exp_q[$];
  logic [34:0] got_e;
  logic [31:0] d[6];
  logic [7:0] msk[6] = '{8'hed, 8'h1f, 8'hb7, 8'hf3, 8'hb7, 8'hf3};
  logic [7:0] t1_count;
  logic [7:0] rst[8] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
  int num_errors = 0, n_checks = 0;

  always #12.5 aclk = ~aclk;

  drcc_top #(.NUM_CMP(2)) drcc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cmp_raw, .t1_clk_fall, .pin_direction, .ref_enable_q, .ref_pos_connect_q, .ref_neg_connect_q,
    .ref_pos_source_sel_q, .ref_neg_source_sel_q, .ref_level_q, .ref_out_pin_q, .cmp_enable_q,
    .cmp_speed_power_q, .cmp_hysteresis_enable_q, .cmp_pos_input_sel_q, .cmp_neg_input_sel_q, .cmp_gate_q,
    .cmp_pin_out_q, .cmp_pin_oe_q, .cmp_irq_flag_q);

  drcc_t1_model #(.DIV(8)) drcc_t1_model_inst (.aclk, .aresetn, .run(t1_run), .gate(cmp_gate_q[0]),
    .t1_clk_fall, .t1_count_q(t1_count));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    print_verdict();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Address and data offered together; each released on its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st, input logic [1:0] r);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'b0;
    if (n >= 200)
      hang();
    `CHK("bresp", r, s_axi_bresp)
  endtask

  // Expected word noted first; the monitor compares it when the data arrives
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    @(posedge aclk);
    n = 0;
    exp_q.push_back({r == DRCC_RESP_SLVERR, r, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 200);
    s_axi_rready <= 1'b0;
    if (n >= 200)
      hang();
  endtask

  // Data of an error response carries no meaning, so only the code is compared
  always @(posedge aclk)
    if (s_axi_rvalid && s_axi_rready)
    begin
      got_e = exp_q.pop_front();
      if (got_e[34])
        got_e[31:0] = s_axi_rdata;
      `CHK("read word", got_e[33:0], {s_axi_rresp, s_axi_rdata})
    end

  initial
  begin
    void'($urandom(20322));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(8'(4 * i), {24'h0, rst[i]}, DRCC_RESP_OKAY);
    rd(8'h40, 32'h0, DRCC_RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      d[i] = $urandom;
      if (i == 0 && d[0][3:2] == 2'b11)
        d[0][3] = 1'b0;
      wr(8'(4 * i), d[i], 4'hf, DRCC_RESP_OKAY);
    end
    wr(8'h05, 32'h3, 4'hf, DRCC_RESP_SLVERR);
    wr(8'h04, ~d[1], 4'h0, DRCC_RESP_OKAY);
    cyc(6);
    for (int i = 0; i < 6; i++)
      rd(8'(4 * i), {24'h0, d[i][7:0] & msk[i]} | {25'h0, (i == 2 || i == 4) && d[i][7] && d[i][4], 6'h00},
        DRCC_RESP_OKAY);
    rd(8'h18, {30'h0, d[4][7] && d[4][4], d[2][7] && d[2][4]}, DRCC_RESP_OKAY);
    `CHK("ref ports", {ref_enable_q, ref_pos_source_sel_q, ref_neg_source_sel_q, ref_out_pin_q, ref_level_q},
      {d[0][7], d[0][3:2], d[0][0], d[0][5], d[1][4:0]})
    `CHK("cmp ports", {cmp_enable_q, cmp_speed_power_q, cmp_hysteresis_enable_q, cmp_pos_input_sel_q,
      cmp_neg_input_sel_q}, {d[4][7], d[2][7], d[4][2], d[2][2], d[4][1], d[2][1], d[5][5:4], d[3][5:4],
      d[5][1:0], d[3][1:0]})
    $display("test registers done");
    wr(8'h00, 32'h48, 4'hf, DRCC_RESP_OKAY);
    wr(8'h04, 32'h1f, 4'hf, DRCC_RESP_OKAY);
    cyc(2);
    `CHK("clamp high", {ref_enable_q, ref_pos_connect_q, ref_neg_connect_q, ref_level_q}, 8'h5f)
    wr(8'h00, 32'h01, 4'hf, DRCC_RESP_OKAY);
    wr(8'h04, 32'h00, 4'hf, DRCC_RESP_OKAY);
    cyc(2);
    `CHK("clamp low", {ref_enable_q, ref_pos_connect_q, ref_neg_connect_q, ref_level_q}, 8'h20)
    $display("test clamp done");
    wr(8'h10, 32'h84, 4'hf, DRCC_RESP_OKAY);
    wr(8'h14, 32'h00, 4'hf, DRCC_RESP_OKAY);
    wr(8'h0c, 32'hc0, 4'hf, DRCC_RESP_OKAY);
    wr(8'h08, 32'ha4, 4'hf, DRCC_RESP_OKAY);
    cmp_raw <= 2'b11;
    pin_direction <= 2'b00;
    cyc(5);
    wr(8'h1c, 32'h3, 4'hf, DRCC_RESP_OKAY);
    rd(8'h08, 32'he4, DRCC_RESP_OKAY);
    rd(8'h10, 32'hc4, DRCC_RESP_OKAY);
    rd(8'h18, 32'h3, DRCC_RESP_OKAY);
    rd(8'h1c, 32'h0, DRCC_RESP_OKAY);
    `CHK("pin path", {cmp_gate_q[0], cmp_pin_out_q[0], cmp_pin_oe_q[0]}, 3'b111)
    cmp_raw[0] <= 1'b0;
    cyc(5);
    rd(8'h1c, 32'h1, DRCC_RESP_OKAY);
    wr(8'h1c, 32'h1, 4'hf, DRCC_RESP_OKAY);
    wr(8'h0c, 32'h80, 4'hf, DRCC_RESP_OKAY);
    rd(8'h1c, 32'h0, DRCC_RESP_OKAY);
    cmp_raw[0] <= 1'b1;
    cyc(5);
    rd(8'h1c, 32'h1, DRCC_RESP_OKAY);
    wr(8'h1c, 32'h1, 4'hf, DRCC_RESP_OKAY);
    cmp_raw[0] <= 1'b0;
    cyc(5);
    rd(8'h1c, 32'h0, DRCC_RESP_OKAY);
    wr(8'h08, 32'hb4, 4'hf, DRCC_RESP_OKAY);
    pin_direction <= 2'b01;
    cyc(5);
    rd(8'h08, 32'hf4, DRCC_RESP_OKAY);
    `CHK("pin input", cmp_pin_oe_q[0], 1'b0)
    wr(8'h08, 32'h34, 4'hf, DRCC_RESP_OKAY);
    cyc(5);
    rd(8'h08, 32'h34, DRCC_RESP_OKAY);
    `CHK("cmp off", cmp_enable_q[0], 1'b0)
    $display("test comparator done");
    pin_direction <= 2'b00;
    wr(8'h08, 32'ha5, 4'hf, DRCC_RESP_OKAY);
    t1_run <= 1'b1;
    cyc(20);
    t1_run <= 1'b0;
    cyc(3);
    cmp_raw[0] <= 1'b1;
    cyc(6);
    rd(8'h08, 32'he5, DRCC_RESP_OKAY);
    `CHK("gate held", cmp_gate_q[0], 1'b0)
    t1_run <= 1'b1;
    cyc(20);
    `CHK("gate latched", {cmp_gate_q[0], cmp_pin_out_q[0]}, 2'b11)
    `CHK("t1 counted", t1_count != 8'h00, 1'b1)
    t1_run <= 1'b0;
    $display("test sync done");
    wr(8'h00, 32'ha4, 4'hf, DRCC_RESP_OKAY);
    wr(8'h04, 32'h15, 4'hf, DRCC_RESP_OKAY);
    aresetn <= 1'b0;
    cyc(2);
    `CHK("in reset", {ref_enable_q, ref_out_pin_q, ref_level_q, cmp_speed_power_q}, 9'h003)
    aresetn <= 1'b1;
    rd(8'h00, 32'h0, DRCC_RESP_OKAY);
    rd(8'h04, 32'h0, DRCC_RESP_OKAY);
    cyc(2);
    $display("test second reset done");
    print_verdict();
  end
endmodule // tb_top
